// ==== rtl/tse_pkg.sv ====
// Package of the timer status and event generation block: map, fields, resets.
// Assumes one 200 MHz clock (hclk) and an AHB-Lite slave port with 32-bit data.
// Contract
// (R01) Update flag sets on update, clears on zero-write
// (R02) Repetition over/underflow updates while update enabled
// (R03) Software reinit updates when source and disable zero
// (R04) Trigger reinit updates when source and disable zero
// (R05) Output mode: compare match sets channel flag
// (R06) Capture sets flag; zero-write or capture read clears
// (R07) Capture with flag set raises over-capture flag
// (R08) Update-generate write one reinits counter, self-clears
// (R09) Update clears prescaler count, keeps division factor
// (R10) Software update: down loads reload, else zero
// (R11) Channel event-generate write one makes event, self-clears
// (R12) Software event, output: flag, interrupt, DMA request
// (R13) Software event, input: capture counter, set flag
// (R14) Software capture with flag set sets over-capture
// (R15) Update interrupt only while flag and enable set
// (R16) Writing ones keeps flags; reserved bits read zero
package tse_pkg;

  // Register byte offsets
  localparam logic [7:0] TSE_OFS_CTRL = 8'h00;  // Control: disable, source, direction
  localparam logic [7:0] TSE_OFS_IEN  = 8'h0c;  // Interrupt and DMA enables
  localparam logic [7:0] TSE_OFS_STS  = 8'h10;  // timer_status_flags
  localparam logic [7:0] TSE_OFS_CEG  = 8'h14;  // timer_event_trigger
  localparam logic [7:0] TSE_OFS_CHM  = 8'h18;  // Channel one direction
  localparam logic [7:0] TSE_OFS_CNT  = 8'h24;  // counter_value
  localparam logic [7:0] TSE_OFS_ARR  = 8'h2c;  // auto_reload_value
  localparam logic [7:0] TSE_OFS_CC1  = 8'h34;  // chan1_compare_capture_value

  // Field positions
  localparam int TSE_B_UD   = 0;  // update_disable
  localparam int TSE_B_URS  = 1;  // update_request_source
  localparam int TSE_B_DOWN = 2;  // Count down
  localparam int TSE_B_CTR  = 3;  // Center-aligned
  localparam int TSE_B_UPDATE_IRQ_ENABLE = 0;  // update_irq_enable
  localparam int TSE_B_CIEN = 1;  // chan1_irq_enable
  localparam int TSE_B_CDEN = 9;  // chan1_dma_enable
  localparam int TSE_B_UF   = 0;  // update_flag
  localparam int TSE_B_CF   = 1;  // chan1_event_flag
  localparam int TSE_B_OVC  = 9;  // chan1_overcapture_flag
  localparam int TSE_B_UG   = 0;  // update_generate
  localparam int TSE_B_CG   = 1;  // chan1_event_generate
  localparam int TSE_B_IN   = 0;  // Channel one is input

  // Reset values
  localparam logic [3:0]  TSE_RST_CTRL = 4'h0;
  localparam logic [15:0] TSE_RST_VAL  = 16'h0000;
  localparam logic [15:0] TSE_RST_ARR  = 16'hffff;

  // Bus phase states, Gray coded along idle, wait, done
  typedef enum logic [1:0] {
    TSE_BP_IDLE  = 2'b00,
    TSE_BP_RWAIT = 2'b01,
    TSE_BP_RDONE = 2'b11
  } tse_bus_t;

endpackage : tse_pkg

// ==== rtl/tse_timer_status.sv ====
// Timer status flags, software event generation and a small counter core.
// Assumes a single-slave AHB-Lite bus on hclk; timer strobes are hclk-synchronous.
`timescale 1ns/1ps
`default_nettype none

module tse_timer_status
  import tse_pkg::*;
#(
  parameter int CW = 16  // Counter width
) (
  // Clock and reset
  input  wire logic          hclk,
  input  wire logic          hresetn,
  // AHB-Lite slave
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic               hresp,
  output logic [31:0]        hrdata,
  // Timer strobes from the same clock domain
  input  wire logic          count_tick,
  input  wire logic          rep_overflow,
  input  wire logic          trigger_reinit,
  input  wire logic          capture_strobe,
  // Event outputs
  output logic               update_event,
  output logic               prescaler_clear,
  output logic               chan1_dma_req,
  output logic               update_irq,
  output logic               irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  tse_bus_t          bus_st;          // Bus phase
  tse_bus_t          next_bus_st;     // Next bus phase
  logic              wr_pend;         // Write data phase active
  logic [7:0]        wr_addr;         // Latched write offset
  logic [7:0]        rd_addr;         // Latched read offset
  logic              addr_ok;         // Address phase taken
  logic              rd_sample;       // Read data captured this cycle
  logic [3:0]        ctrl;            // Control bits
  logic [15:0]       ien;             // Enable register
  logic              chan_in;         // Channel one is input
  logic [CW-1:0]     cnt;             // counter_value
  logic [CW-1:0]     arr;             // auto_reload_value
  logic [CW-1:0]     cc1;             // chan1_compare_capture_value
  logic              cnt_dir_dn;      // Center mode direction
  logic              update_flag;     // Update flag
  logic              chan1_flag;      // chan1_event_flag
  logic              ovc_flag;        // chan1_overcapture_flag
  logic              sw_ug;           // Software update request
  logic              sw_cg;           // Software channel event request
  logic              wr_sts;          // Status write
  logic              reinit;          // Counter reinitialise
  logic              upd_ev;          // Update event this cycle
  logic              match_set;       // Compare match
  logic              cap_ev;          // Capture this cycle
  logic              ch1_set;         // Channel flag set
  logic              ch1_clr;         // Channel flag clear
  logic [15:0]       sts_word;        // Status readback
  logic [31:0]       rd_word;         // Read mux

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Decode of one register offset
  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
    is_reg = (a == ofs);
  endfunction : is_reg

  // Zero-extend a counter-width value to the bus
  function automatic logic [31:0] ext(input logic [CW-1:0] v);
    ext = 32'h0000_0000;
    ext[CW-1:0] = v;
  endfunction : ext

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave

  // Address phase accepted
  assign addr_ok = hsel & htrans[1] & hready;
  // Reads take one wait state; writes none
  assign hreadyout = (bus_st != TSE_BP_RWAIT);
  // Response is always OKAY
  assign hresp = 1'b0;
  // Read data sampled in the wait cycle
  assign rd_sample = (bus_st == TSE_BP_RWAIT);

  // Next bus phase
  always_comb begin
    next_bus_st = bus_st;
    case (bus_st)
      TSE_BP_IDLE: begin
        if (addr_ok && !hwrite) begin
          next_bus_st = TSE_BP_RWAIT;
        end
      end
      TSE_BP_RWAIT: begin
        next_bus_st = TSE_BP_RDONE;
      end
      TSE_BP_RDONE: begin
        if (addr_ok && !hwrite) begin
          next_bus_st = TSE_BP_RWAIT;
        end else begin
          next_bus_st = TSE_BP_IDLE;
        end
      end
      default: begin
        next_bus_st = TSE_BP_IDLE;
      end
    endcase
  end

  // Bus phase register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_st <= TSE_BP_IDLE;
    end else begin
      bus_st <= next_bus_st;
    end
  end

  // Address latches and write pending flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      rd_addr <= 8'h00;
    end else begin
      wr_pend <= addr_ok & hwrite;
      if (addr_ok && hwrite) begin
        wr_addr <= haddr[7:0];
      end
      if (addr_ok && !hwrite) begin
        rd_addr <= haddr[7:0];
      end
    end
  end

  // Status word, reserved bits zero [R16]
  always_comb begin
    sts_word = 16'h0000;
    sts_word[TSE_B_UF] = update_flag;
    sts_word[TSE_B_CF] = chan1_flag;
    sts_word[TSE_B_OVC] = ovc_flag;
  end

  // Read mux; event trigger reads zero, unmapped reads zero [R08] [R16]
  always_comb begin
    rd_word = 32'h0000_0000;
    if (is_reg(rd_addr, TSE_OFS_CTRL)) begin
      rd_word[3:0] = ctrl;
    end else if (is_reg(rd_addr, TSE_OFS_IEN)) begin
      rd_word[15:0] = ien;
    end else if (is_reg(rd_addr, TSE_OFS_STS)) begin
      rd_word[15:0] = sts_word;
    end else if (is_reg(rd_addr, TSE_OFS_CHM)) begin
      rd_word[TSE_B_IN] = chan_in;
    end else if (is_reg(rd_addr, TSE_OFS_CNT)) begin
      rd_word = ext(cnt);
    end else if (is_reg(rd_addr, TSE_OFS_ARR)) begin
      rd_word = ext(arr);
    end else if (is_reg(rd_addr, TSE_OFS_CC1)) begin
      rd_word = ext(cc1);
    end
  end

  // Read data register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_sample) begin
      hrdata <= rd_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers

  // Write strobes; trigger bits act for one cycle only [R08] [R11]
  assign sw_ug  = wr_pend & is_reg(wr_addr, TSE_OFS_CEG) & hwdata[TSE_B_UG];
  assign sw_cg  = wr_pend & is_reg(wr_addr, TSE_OFS_CEG) & hwdata[TSE_B_CG];
  assign wr_sts = wr_pend & is_reg(wr_addr, TSE_OFS_STS);

  // Control, enables and channel direction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl    <= TSE_RST_CTRL;
      ien     <= TSE_RST_VAL;
      chan_in <= 1'b0;
    end else if (wr_pend) begin
      if (is_reg(wr_addr, TSE_OFS_CTRL)) begin
        ctrl <= hwdata[3:0];
      end else if (is_reg(wr_addr, TSE_OFS_IEN)) begin
        ien <= 16'h0000;
        ien[TSE_B_UPDATE_IRQ_ENABLE] <= hwdata[TSE_B_UPDATE_IRQ_ENABLE];
        ien[TSE_B_CIEN] <= hwdata[TSE_B_CIEN];
        ien[TSE_B_CDEN] <= hwdata[TSE_B_CDEN];
      end else if (is_reg(wr_addr, TSE_OFS_CHM)) begin
        chan_in <= hwdata[TSE_B_IN];
      end
    end
  end

  // Auto-reload value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      arr <= TSE_RST_ARR[CW-1:0];
    end else if (wr_pend && is_reg(wr_addr, TSE_OFS_ARR)) begin
      arr <= hwdata[CW-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Update events

  // Reinitialise on software request or trigger [R08]
  assign reinit = sw_ug | trigger_reinit;
  // Update sources gated by disable; software and trigger also by request source [R02] [R03] [R04]
  assign upd_ev = ~ctrl[TSE_B_UD] & (rep_overflow | ((sw_ug | trigger_reinit) & ~ctrl[TSE_B_URS]));

  // Update flag: set wins over zero-write, ones keep it [R01] [R16]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      update_flag <= 1'b0;
    end else if (upd_ev) begin
      update_flag <= 1'b1;
    end else if (wr_sts && !hwdata[TSE_B_UF]) begin
      update_flag <= 1'b0;
    end
  end

  // Update and prescaler count clear pulses [R09]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      update_event    <= 1'b0;
      prescaler_clear <= 1'b0;
    end else begin
      update_event    <= upd_ev;
      prescaler_clear <= upd_ev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter

  // Counter: reinit loads reload when down and not center-aligned, else zero [R10]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt        <= TSE_RST_VAL[CW-1:0];
      cnt_dir_dn <= 1'b0;
    end else if (reinit) begin
      cnt        <= (ctrl[TSE_B_DOWN] && !ctrl[TSE_B_CTR]) ? arr : '0;  // [R10]
      cnt_dir_dn <= 1'b0;
    end else if (wr_pend && is_reg(wr_addr, TSE_OFS_CNT)) begin
      cnt <= hwdata[CW-1:0];
    end else if (count_tick) begin
      if (ctrl[TSE_B_CTR]) begin
        // Center-aligned: up to reload, then down to zero
        if (!cnt_dir_dn) begin
          cnt        <= (cnt >= arr) ? cnt - 1'b1 : cnt + 1'b1;
          cnt_dir_dn <= (cnt >= arr);
        end else begin
          cnt        <= (cnt == '0) ? cnt + 1'b1 : cnt - 1'b1;
          cnt_dir_dn <= (cnt != '0);
        end
      end else if (ctrl[TSE_B_DOWN]) begin
        cnt <= (cnt == '0) ? arr : cnt - 1'b1;
      end else begin
        cnt <= (cnt >= arr) ? '0 : cnt + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel one

  // Compare match in output mode [R05]
  assign match_set = ~chan_in & count_tick & (cnt == cc1);
  // Capture by strobe or software in input mode [R06] [R13]
  assign cap_ev = chan_in & (capture_strobe | sw_cg);
  // Flag set sources, software event in output mode [R12]
  assign ch1_set = match_set | cap_ev | (~chan_in & sw_cg);
  // Clear by zero-write or by reading the capture value [R06]
  assign ch1_clr = (wr_sts & ~hwdata[TSE_B_CF]) | (rd_sample & is_reg(rd_addr, TSE_OFS_CC1));

  // Capture/compare value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cc1 <= TSE_RST_VAL[CW-1:0];
    end else if (cap_ev) begin
      cc1 <= cnt;  // [R13]
    end else if (!chan_in && wr_pend && is_reg(wr_addr, TSE_OFS_CC1)) begin
      cc1 <= hwdata[CW-1:0];
    end
  end

  // Channel event flag, set wins over clear [R05] [R06] [R12]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan1_flag <= 1'b0;
    end else if (ch1_set) begin
      chan1_flag <= 1'b1;
    end else if (ch1_clr) begin
      chan1_flag <= 1'b0;
    end
  end

  // Over-capture flag, input mode only [R07] [R14]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovc_flag <= 1'b0;
    end else if (cap_ev && chan1_flag) begin
      ovc_flag <= 1'b1;
    end else if (wr_sts && !hwdata[TSE_B_OVC]) begin
      ovc_flag <= 1'b0;
    end
  end

  // DMA request pulse on each channel event when enabled [R12]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan1_dma_req <= 1'b0;
    end else begin
      chan1_dma_req <= ch1_set & ien[TSE_B_CDEN];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts

  // Update interrupt request [R15]
  assign update_irq = update_flag & ien[TSE_B_UPDATE_IRQ_ENABLE];
  // Combined level, enables act as mask [R12]
  assign irq = update_irq | (chan1_flag & ien[TSE_B_CIEN]);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  // Software update write with update allowed
  sequence s_ug_write;
    sw_ug && !ctrl[TSE_B_UD] && !ctrl[TSE_B_URS];
  endsequence

  // Software capture with flag already set
  sequence s_sw_recapture;
    sw_cg && chan_in && chan1_flag;
  endsequence

  AST_UF_SET: assert property (@(posedge hclk) disable iff (!hresetn)  // [R01]
    rep_overflow && !ctrl[TSE_B_UD] |=> update_flag && update_event)
    else $error("update flag not set on overflow");

  AST_UF_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)  // [R16]
    update_flag && !(wr_sts && !hwdata[TSE_B_UF]) |=> update_flag)
    else $error("update flag lost without zero write");

  AST_UD_BLOCK: assert property (@(posedge hclk) disable iff (!hresetn)  // [R02]
    ctrl[TSE_B_UD] && !update_flag && !wr_pend |=> !update_flag)
    else $error("update flag set while disabled");

  AST_SW_UG: assert property (@(posedge hclk) disable iff (!hresetn)  // [R03]
    s_ug_write |=> update_flag && update_event && prescaler_clear)
    else $error("software update not taken");

  AST_TRIG: assert property (@(posedge hclk) disable iff (!hresetn)  // [R04]
    trigger_reinit && !ctrl[TSE_B_UD] && !ctrl[TSE_B_URS] |=> update_event)
    else $error("trigger did not update");

  AST_MATCH: assert property (@(posedge hclk) disable iff (!hresetn)  // [R05]
    !chan_in && count_tick && (cnt == cc1) |=> chan1_flag)
    else $error("compare match missed");

  AST_CAPT: assert property (@(posedge hclk) disable iff (!hresetn)  // [R06]
    chan_in && capture_strobe |=> chan1_flag && (cc1 == $past(cnt)))
    else $error("capture not stored");

  AST_RDCLR: assert property (@(posedge hclk) disable iff (!hresetn)  // [R06]
    rd_sample && is_reg(rd_addr, TSE_OFS_CC1) && !ch1_set |=> !chan1_flag)
    else $error("capture read did not clear flag");

  AST_OVC: assert property (@(posedge hclk) disable iff (!hresetn)  // [R07]
    cap_ev && chan1_flag |=> ovc_flag)
    else $error("over-capture missed");

  AST_CEG_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)  // [R08]
    rd_sample && is_reg(rd_addr, TSE_OFS_CEG) |=> hrdata == 32'h0000_0000 && hreadyout)
    else $error("trigger register not zero");

  AST_RELOAD: assert property (@(posedge hclk) disable iff (!hresetn)  // [R10]
    sw_ug && ctrl[TSE_B_DOWN] && !ctrl[TSE_B_CTR] |=> cnt == $past(arr))
    else $error("down reload wrong");

  AST_CG_OUT: assert property (@(posedge hclk) disable iff (!hresetn)  // [R11]
    sw_cg && !chan_in && ien[TSE_B_CDEN] |=> chan1_flag && chan1_dma_req ##1 (!chan1_dma_req || $past(ch1_set)))
    else $error("software channel event lost");

  AST_SW_OVC: assert property (@(posedge hclk) disable iff (!hresetn)  // [R14]
    s_sw_recapture |=> ovc_flag && (cc1 == $past(cnt)))
    else $error("software over-capture missed");

  AST_UIRQ: assert property (@(posedge hclk) disable iff (!hresetn)  // [R15]
    upd_ev && ien[TSE_B_UPDATE_IRQ_ENABLE] && !(wr_pend && is_reg(wr_addr, TSE_OFS_IEN)) |=> update_irq && irq)
    else $error("update interrupt missing");

endmodule : tse_timer_status

`default_nettype wire

// ==== verification/tse_timer_status_tb.sv ====
// Self-checking bench of the timer status and event generation block.
// Assumes the design files and tse_pkg are compiled first; one 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module tse_timer_status_tb;
  import tse_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bench signals
  logic        hclk;           // Bus and timer clock
  logic        hresetn;        // Active-low reset
  logic        hsel;           // Slave select
  logic [31:0] haddr;          // Byte address
  logic [1:0]  htrans;         // Transfer type
  logic        hwrite;         // Write strobe
  logic [2:0]  hsize;          // Word size
  logic [31:0] hwdata;         // Write data
  logic        hready;         // Bus ready, looped back
  logic        hreadyout;      // Slave ready
  logic        hresp;          // Slave response
  logic [31:0] hrdata;         // Read data
  logic        count_tick;     // Counter advance
  logic        rep_overflow;   // Repetition wrap
  logic        trigger_reinit; // Trigger reinit
  logic        capture_strobe; // Input capture
  logic        update_event;   // Update pulse
  logic        prescaler_clear;// Prescaler clear pulse
  logic        chan1_dma_req;  // Channel DMA pulse
  logic        update_irq;     // Update interrupt level
  logic        irq;            // Combined interrupt
  int          fails;          // Mismatch count
  int          total_checks;   // Comparison count
  logic [31:0] rd;             // Last read word

  assign hready = hreadyout;  // Single slave drives the bus ready

  tse_timer_status dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .count_tick(count_tick),
    .rep_overflow(rep_overflow), .trigger_reinit(trigger_reinit),
    .capture_strobe(capture_strobe), .update_event(update_event),
    .prescaler_clear(prescaler_clear), .chan1_dma_req(chan1_dma_req),
    .update_irq(update_irq), .irq(irq)
  );

  // Clock of 5 ns period
  always #2.5 hclk = ~hclk;

  ////////////////////////////////////////////////////////////////////////////
  // Reporting
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  // Compare a register word
  task automatic chk_reg(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_reg

  // Compare a single output level
  task automatic chk_bit(input string nm, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk_bit

  ////////////////////////////////////////////////////////////////////////////
  // Bus access: address phase held until ready, then data phase until ready
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd);
    int n;
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'b10;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'b00;
    hwdata <= wd;
    n = (n >= 50) ? 100 : 0;
    while (n < 50) begin
      @(posedge hclk);
      n++;
      if (hreadyout === 1'b1) break;
    end
    if (n >= 50) begin
      fails++;
      $display("[FAIL] bus wait expected ready seen timeout");
      complete_run();
    end
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr

  // Read and compare
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h00000000);
    chk_reg(nm, exp, rd);
  endtask : rdc

  // One-cycle timer strobe; returns in the cycle after it was taken
  task automatic strobe(input int k);
    @(posedge hclk);
    case (k)
      0: rep_overflow <= 1'b1;
      1: trigger_reinit <= 1'b1;
      2: capture_strobe <= 1'b1;
      default: count_tick <= 1'b1;
    endcase
    @(posedge hclk);
    {rep_overflow, trigger_reinit, capture_strobe, count_tick} <= 4'h0;
    #1;
  endtask : strobe

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic sc_reset();
    rdc("status reset", TSE_OFS_STS, 32'h00000000);
    rdc("trigger reset", TSE_OFS_CEG, 32'h00000000);
    rdc("reload reset", TSE_OFS_ARR, 32'h0000ffff);
  endtask : sc_reset

  // Repetition wrap updates, flag stickiness and update interrupt gating
  task automatic sc_rep_update();
    wr(TSE_OFS_CTRL, 32'h0);
    wr(TSE_OFS_IEN, 32'h1);
    strobe(0);
    chk_bit("update_event", 1'b1, update_event);
    chk_bit("prescaler_clear", 1'b1, prescaler_clear);
    chk_bit("update_irq", 1'b1, update_irq);
    chk_bit("irq", 1'b1, irq);
    wr(TSE_OFS_STS, 32'h00000001);
    rdc("flag after one", TSE_OFS_STS, 32'h00000001);
    wr(TSE_OFS_STS, 32'h0);
    rdc("flag after zero", TSE_OFS_STS, 32'h00000000);
    chk_bit("update_irq clear", 1'b0, update_irq);
    wr(TSE_OFS_IEN, 32'h0);
    strobe(0);
    chk_bit("update_irq masked", 1'b0, update_irq);
    wr(TSE_OFS_STS, 32'h0);
    wr(TSE_OFS_CTRL, 32'h1);
    strobe(0);
    chk_bit("update_event disabled", 1'b0, update_event);
    rdc("flag disabled", TSE_OFS_STS, 32'h00000000);
  endtask : sc_rep_update

  // Software update in down and up modes, and with the request source set
  task automatic sc_sw_update();
    wr(TSE_OFS_ARR, 32'h55);
    wr(TSE_OFS_CNT, 32'h12);
    wr(TSE_OFS_CTRL, 32'h4);
    wr(TSE_OFS_CEG, 32'h1);
    rdc("count down reload", TSE_OFS_CNT, 32'h00000055);
    rdc("flag sw update", TSE_OFS_STS, 32'h00000001);
    rdc("generate self clear", TSE_OFS_CEG, 32'h0);
    wr(TSE_OFS_STS, 32'h0);
    wr(TSE_OFS_CTRL, 32'h0);
    wr(TSE_OFS_CEG, 32'h1);
    rdc("count up cleared", TSE_OFS_CNT, 32'h00000000);
    wr(TSE_OFS_CTRL, 32'hc);
    wr(TSE_OFS_CNT, 32'h12);
    wr(TSE_OFS_CEG, 32'h1);
    rdc("count center cleared", TSE_OFS_CNT, 32'h0);
    wr(TSE_OFS_STS, 32'h0);
    wr(TSE_OFS_CTRL, 32'h2);
    wr(TSE_OFS_CNT, 32'h12);
    wr(TSE_OFS_CEG, 32'h1);
    rdc("count source set", TSE_OFS_CNT, 32'h0);
    rdc("flag source set", TSE_OFS_STS, 32'h0);
    wr(TSE_OFS_CNT, 32'h12);
    wr(TSE_OFS_CEG, 32'h0);
    rdc("zero write keeps count", TSE_OFS_CNT, 32'h12);
  endtask : sc_sw_update

  // Trigger reinitialisation updates with both controls clear, not with the request source set
  task automatic sc_trigger();
    wr(TSE_OFS_CTRL, 32'h0);
    strobe(1);
    chk_bit("update_event trigger", 1'b1, update_event);
    rdc("flag trigger", TSE_OFS_STS, 32'h00000001);
    wr(TSE_OFS_STS, 32'h0);
    wr(TSE_OFS_CTRL, 32'h2);
    strobe(1);
    chk_bit("update_event blocked", 1'b0, update_event);
    wr(TSE_OFS_CTRL, 32'h0);
  endtask : sc_trigger

  // Compare match and software channel event in output mode
  task automatic sc_compare();
    wr(TSE_OFS_CHM, 32'h0);
    wr(TSE_OFS_CC1, 32'h2);
    wr(TSE_OFS_CNT, 32'h0);
    strobe(3);
    strobe(3);
    rdc("no match yet", TSE_OFS_STS, 32'h0);
    strobe(3);
    rdc("match flag", TSE_OFS_STS, 32'h00000002);
    wr(TSE_OFS_STS, 32'h0);
    wr(TSE_OFS_IEN, 32'h2);
    wr(TSE_OFS_CEG, 32'h2);
    rdc("sw event flag", TSE_OFS_STS, 32'h00000002);
    chk_bit("irq sw event", 1'b1, irq);
    rdc("event self clear", TSE_OFS_CEG, 32'h0);
    wr(TSE_OFS_STS, 32'h0);
  endtask : sc_compare

  // Input capture, read clear, over-capture, software capture
  task automatic sc_capture();
    wr(TSE_OFS_CHM, 32'h1);
    wr(TSE_OFS_IEN, 32'h202);
    wr(TSE_OFS_CNT, 32'h1234);
    strobe(2);
    chk_bit("dma capture", 1'b1, chan1_dma_req);
    chk_bit("irq capture", 1'b1, irq);
    rdc("capture flag", TSE_OFS_STS, 32'h00000002);
    rdc("capture value", TSE_OFS_CC1, 32'h1234);
    rdc("read clears flag", TSE_OFS_STS, 32'h0);
    strobe(2);
    strobe(2);
    rdc("overcapture", TSE_OFS_STS, 32'h00000202);
    wr(TSE_OFS_STS, 32'h0);
    wr(TSE_OFS_CNT, 32'h0abc);
    wr(TSE_OFS_CEG, 32'h2);
    #1;
    chk_bit("dma sw capture", 1'b1, chan1_dma_req);
    rdc("sw capture value", TSE_OFS_CC1, 32'h0abc);
    wr(TSE_OFS_CEG, 32'h2);
    wr(TSE_OFS_CEG, 32'h2);
    rdc("sw overcapture", TSE_OFS_STS, 32'h00000202);
    wr(TSE_OFS_STS, 32'hffffffff);
    rdc("ones keep flags", TSE_OFS_STS, 32'h00000202);
    rdc("unmapped", 8'h40, 32'h0);
    chk_bit("hresp okay", 1'b0, hresp);
    wr(TSE_OFS_STS, 32'h0);
    rdc("all cleared", TSE_OFS_STS, 32'h0);
  endtask : sc_capture

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    count_tick = 1'b0;
    rep_overflow = 1'b0;
    trigger_reinit = 1'b0;
    capture_strobe = 1'b0;
    fails = 0;
    total_checks = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    sc_reset();
    sc_rep_update();
    sc_sw_update();
    sc_trigger();
    sc_compare();
    sc_capture();
    complete_run();
  end

endmodule : tse_timer_status_tb

`default_nettype wire
